// ===== hw/rth_pkg.sv
// package for the return-to-home sequencer: register map, fields, timing
package rth_pkg;
    // register byte offsets
    localparam logic [7:0] RTH_REG_CTRL = 8'h00;
    localparam logic [7:0] RTH_REG_START_SPEED = 8'h04;
    localparam logic [7:0] RTH_REG_RUN_SPEED = 8'h08;
    localparam logic [7:0] RTH_REG_PUSH_CURRENT = 8'h0c;
    localparam logic [7:0] RTH_REG_OFFSET = 8'h10;
    localparam logic [7:0] RTH_REG_STATUS = 8'h14;
    localparam logic [7:0] RTH_REG_APPROACH = 8'h18;
    // control field positions
    localparam int RTH_CTRL_START = 0;
    localparam int RTH_CTRL_PUSH = 1;
    localparam int RTH_CTRL_DIR = 2;
    localparam int RTH_CTRL_APERTURE = 3;
    localparam int RTH_CTRL_PHASE = 4;
    // status field positions
    localparam int RTH_STAT_READY = 0;
    localparam int RTH_STAT_DONE = 1;
    localparam int RTH_STAT_BUSY = 2;
    // reset values and the push current maximum
    localparam logic [19:0] RTH_START_SPEED_RST = 20'h001f4;
    localparam logic [19:0] RTH_RUN_SPEED_RST = 20'h003e8;
    localparam logic [10:0] RTH_PUSH_CURRENT_RST = 11'h3e8;
    localparam logic [10:0] RTH_PUSH_CURRENT_MAX = 11'h3e8;
    localparam logic [23:0] RTH_OFFSET_RST = 24'h000000;
    // speeds in Hz
    localparam logic [19:0] RTH_APPROACH_LIMIT_HZ = 20'h001f4;
    // escape distance in steps
    localparam logic [23:0] RTH_ESCAPE_STEPS = 24'h0000c8;
    // halt dwell between escape and resumed search
    localparam int RTH_HALT_NS = 1000;
    localparam int RTH_CLK_NS = 10;
    localparam logic [7:0] RTH_HALT_CYCLES = 8'(RTH_HALT_NS / RTH_CLK_NS);
    // step generator: 100 MHz clock, step every CLK_HZ/speed cycles
    localparam logic [27:0] RTH_CLK_HZ = 28'h5f5e100;
    // axi responses
    localparam logic [1:0] RTH_RESP_OKAY = 2'b00;
    localparam logic [1:0] RTH_RESP_SLVERR = 2'b10;
    // sequencer states
    typedef enum logic [3:0] {
        RTH_IDLE, RTH_SEEK, RTH_ESCAPE, RTH_CLEAR, RTH_HALT, RTH_FIND, RTH_OFFSET_MOVE,
        RTH_DONE
    } rth_state_t;
endpackage

// ===== hw/rth_step_gen.sv
// step pulse generator: divides the clock to a requested step rate
`timescale 1ns/1ps
`default_nettype none
module rth_step_gen
    import rth_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    input wire logic run, // generate steps while high
    input wire logic [19:0] speed_hz, // step rate in Hz
    output logic step // one-cycle step enable
);
    logic [27:0] acc;
    logic [27:0] sum;

    // fractional accumulator, so any rate divides without a divider
    assign sum = acc + {8'h00, speed_hz};

    // step fires when the accumulator wraps past the clock rate
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            acc <= 28'h0000000;
            step <= 1'b0;
        end else if (sum >= RTH_CLK_HZ) begin
            acc <= sum - RTH_CLK_HZ;
            step <= 1'b1;
        end else begin
            acc <= sum;
            step <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== hw/rth_sequencer.sv
// return-to-home sequencer with axi4-lite register slave
// Operation
// RQ1 - final approach speed is start speed, max 500 Hz
// RQ2 - two-sensor: 200 more steps after leaving limit
// RQ3 - two-sensor: reverse at limit until it clears
// RQ4 - with external signals: 200 steps then halt once
// RQ5 - resume until enabled signals seen, then complete
// RQ6 - push mode: reverse on pressing mechanical stopper
// RQ7 - push mode: move 200 steps off the end
// RQ8 - push with external signals: 200 steps, halt, search
// RQ9 - host keeps push speed at most 500 r/min
// RQ10 - raise origin-done when search finishes
// RQ11 - host starts only when ready, drops request after
// RQ12 - one bit enables external aperture input
// RQ13 - push current setting 0 to 1000, 0.1 % units
// RQ14 - detect push contact as stall at limited current
// RQ15 - do home offset move before completion
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module rth_sequencer
    import rth_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic origin_search_request, // host request pin
    output logic ready, // idle and able to start
    output logic origin_done, // origin established
    input wire logic positive_limit_sensor, // limit sensor, positive end
    input wire logic negative_limit_sensor, // limit sensor, negative end
    input wire logic external_aperture_input, // aperture sensor
    input wire logic excitation_phase_marker, // phase marker
    input wire logic stall_detect, // drive reports stall at limited current
    output logic motor_step, // one-cycle step pulse
    output logic motor_dir, // 1 = positive direction
    output logic [10:0] current_limit, // operating current, 0.1 % units
    output logic current_limit_en // limited current active
);
    // pin synchronisers, two stages each
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1 <= 6'h00;
            pin_s2 <= 6'h00;
        end else begin
            pin_s1 <= {origin_search_request, positive_limit_sensor, negative_limit_sensor,
                       external_aperture_input, excitation_phase_marker, stall_detect};
            pin_s2 <= pin_s1;
        end
    end
    logic req_in, pos_ls, neg_ls, aperture, phase, stall;
    assign {req_in, pos_ls, neg_ls, aperture, phase, stall} = pin_s2;

    // configuration registers
    logic start_cmd;
    logic push_mode;
    logic start_dir;
    logic use_aperture;
    logic use_phase;
    logic [19:0] seek_start_speed;
    logic [19:0] seek_run_speed;
    logic [10:0] push_current;
    logic [23:0] home_offset;

    // axi write channel: take address and data in either order
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RTH_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr <= RTH_REG_OFFSET && aw_addr[1:0] == 2'b00)
                    ? RTH_RESP_OKAY : RTH_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // byte-lane merge of the held write data
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    logic [31:0] ctrl_word, start_word, run_word, cur_word, off_word;
    assign ctrl_word = {27'h0000000, use_phase, use_aperture, start_dir, push_mode, 1'b0};
    assign start_word = {12'h000, seek_start_speed};
    assign run_word = {12'h000, seek_run_speed};
    assign cur_word = {21'h000000, push_current};
    assign off_word = {8'h00, home_offset};
    logic [31:0] ctrl_new, cur_new;
    assign ctrl_new = merge(ctrl_word, w_data, w_strb);
    assign cur_new = merge(cur_word, w_data, w_strb);

    // register writes; the start bit is a self-clearing pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_cmd <= 1'b0;
            push_mode <= 1'b0;
            start_dir <= 1'b0;
            use_aperture <= 1'b0;
            use_phase <= 1'b0;
            seek_start_speed <= RTH_START_SPEED_RST;
            seek_run_speed <= RTH_RUN_SPEED_RST;
            push_current <= RTH_PUSH_CURRENT_RST;
            home_offset <= RTH_OFFSET_RST;
        end else begin
            start_cmd <= 1'b0;
            if (do_write) begin
                unique case (aw_addr)
                    RTH_REG_CTRL: begin
                        start_cmd <= ctrl_new[RTH_CTRL_START];
                        push_mode <= ctrl_new[RTH_CTRL_PUSH];
                        start_dir <= ctrl_new[RTH_CTRL_DIR];
                        use_aperture <= ctrl_new[RTH_CTRL_APERTURE]; // RQ12
                        use_phase <= ctrl_new[RTH_CTRL_PHASE];
                    end
                    RTH_REG_START_SPEED:
                        seek_start_speed <= 20'(merge(start_word, w_data, w_strb));
                    RTH_REG_RUN_SPEED: seek_run_speed <= 20'(merge(run_word, w_data, w_strb));
                    RTH_REG_PUSH_CURRENT: begin
                        // out-of-range values saturate at full rated current
                        push_current <= (cur_new[31:0] > {21'h000000, RTH_PUSH_CURRENT_MAX})
                            ? RTH_PUSH_CURRENT_MAX : cur_new[10:0]; // RQ13
                    end
                    RTH_REG_OFFSET: home_offset <= 24'(merge(off_word, w_data, w_strb));
                    default: ;
                endcase
            end
        end
    end

    // final approach speed clamp
    logic [19:0] final_approach_speed;
    assign final_approach_speed = (seek_start_speed < RTH_APPROACH_LIMIT_HZ)
        ? seek_start_speed : RTH_APPROACH_LIMIT_HZ; // RQ1

    // sequencer
    rth_state_t state;
    logic [23:0] step_cnt;
    logic [7:0] halt_cnt;
    logic seen_stop;
    logic need_ext;
    logic ext_hit;
    logic step_en;
    logic at_limit;
    logic start_req;
    logic req_prev;
    assign need_ext = use_aperture || use_phase;
    assign ext_hit = (!use_aperture || aperture) && (!use_phase || phase);
    assign at_limit = motor_dir ? pos_ls : neg_ls;
    assign start_req = start_cmd || (req_in && !req_prev);
    assign ready = (state == RTH_IDLE) || (state == RTH_DONE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_prev <= 1'b0;
        end else begin
            req_prev <= req_in;
        end
    end

    // state and direction; a step is counted at each step enable in RTH_CLEAR and RTH_OFFSET_MOVE
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= RTH_IDLE;
            motor_dir <= 1'b0;
            step_cnt <= 24'h000000;
            halt_cnt <= 8'h00;
            seen_stop <= 1'b0;
        end else begin
            unique case (state)
                RTH_IDLE, RTH_DONE: begin
                    if (start_req) begin // RQ11
                        state <= RTH_SEEK;
                        motor_dir <= start_dir;
                        seen_stop <= 1'b0;
                    end
                end
                RTH_SEEK: begin
                    // two-sensor: limit reached; push: stall at limited current
                    if (push_mode ? stall : at_limit) begin // RQ14
                        motor_dir <= !motor_dir; // RQ3 RQ6
                        state <= push_mode ? RTH_CLEAR : RTH_ESCAPE;
                        step_cnt <= 24'h000000;
                    end
                end
                RTH_ESCAPE: begin
                    // leave the limit in reverse; the sensor is the one behind us
                    if (!(motor_dir ? neg_ls : pos_ls)) begin // RQ3
                        state <= RTH_CLEAR;
                        step_cnt <= 24'h000000;
                    end
                end
                RTH_CLEAR: begin
                    if (step_en) step_cnt <= step_cnt + 24'h000001;
                    if (step_en && step_cnt == RTH_ESCAPE_STEPS - 24'h000001) begin // RQ2 RQ7
                        step_cnt <= 24'h000000;
                        halt_cnt <= 8'h00;
                        state <= need_ext ? RTH_HALT : RTH_OFFSET_MOVE; // RQ4 RQ8
                    end
                end
                RTH_HALT: begin
                    halt_cnt <= halt_cnt + 8'h01;
                    if (halt_cnt == RTH_HALT_CYCLES - 8'h01) state <= RTH_FIND; // RQ4 RQ8
                end
                RTH_FIND: begin
                    if (ext_hit) begin // RQ5 RQ8
                        state <= RTH_OFFSET_MOVE;
                        step_cnt <= 24'h000000;
                    end
                end
                RTH_OFFSET_MOVE: begin
                    // offset runs in the current travel direction
                    if (step_cnt == home_offset) begin // RQ15
                        state <= RTH_DONE;
                    end else if (step_en) begin
                        step_cnt <= step_cnt + 24'h000001;
                    end
                end
            endcase
        end
    end

    // origin-done flag, cleared on a new start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            origin_done <= 1'b0;
        end else if (state == RTH_OFFSET_MOVE && step_cnt == home_offset) begin
            origin_done <= 1'b1; // RQ10
        end else if (ready && start_req) begin
            origin_done <= 1'b0;
        end
    end

    // speed select: seek at run speed, then start speed; only the last approach is clamped
    logic [19:0] speed;
    logic run;
    always_comb begin
        speed = (state == RTH_SEEK) ? seek_run_speed : seek_start_speed;
        if (state == RTH_FIND || (state == RTH_CLEAR && !need_ext)) speed = final_approach_speed;
        run = !(state == RTH_IDLE || state == RTH_DONE || state == RTH_HALT);
        if (state == RTH_OFFSET_MOVE && step_cnt == home_offset) run = 1'b0;
    end
    assign step_en = motor_step;

    // push current only limited during the push-mode seek toward the stopper
    assign current_limit = push_current; // RQ13
    assign current_limit_en = push_mode && (state == RTH_SEEK); // RQ14

    rth_step_gen u_step (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .speed_hz(speed),
        .step(motor_step)
    );

    // axi read channel, one cycle after the address
    logic [31:0] status_word;
    assign status_word = {29'h00000000, !ready, origin_done, ready} & 32'h00000007;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RTH_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RTH_RESP_OKAY;
            unique case (s_axi_araddr)
                RTH_REG_CTRL: s_axi_rdata <= ctrl_word;
                RTH_REG_START_SPEED: s_axi_rdata <= start_word;
                RTH_REG_RUN_SPEED: s_axi_rdata <= run_word;
                RTH_REG_PUSH_CURRENT: s_axi_rdata <= cur_word;
                RTH_REG_OFFSET: s_axi_rdata <= off_word;
                RTH_REG_STATUS: s_axi_rdata <= status_word;
                RTH_REG_APPROACH: s_axi_rdata <= {12'h000, final_approach_speed};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RTH_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/rth_sequencer_sva.sv
// port-level assertions for the return-to-home sequencer
`timescale 1ns/1ps
`default_nettype none
module rth_sequencer_sva
    import rth_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic ready, // idle
    input wire logic origin_done, // done flag
    input wire logic motor_step, // step pulse
    input wire logic motor_dir, // direction
    input wire logic [10:0] current_limit, // push current
    input wire logic current_limit_en, // push active
    input wire logic stall_detect, // stall in
    input wire logic positive_limit_sensor // limit in
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write channels taken at one edge
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_write_answer: assert property (s_write_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    a_done_ready: assert property (origin_done |-> ready)
        else $error("done without ready");
    a_start_clears: assert property ($fell(ready) |-> ##[0:1] !origin_done)
        else $error("done kept across start");
    a_current_range: assert property (current_limit <= RTH_PUSH_CURRENT_MAX)
        else $error("push current out of range");
    // no motion once completion is flagged, offset must come first
    a_done_quiet: assert property (origin_done && $past(origin_done) |-> !motor_step)
        else $error("step after done");
    a_stall_reverse: assert property ($rose(stall_detect) && current_limit_en
        |-> ##[1:8] $changed(motor_dir))
        else $error("no reversal on stall");
    a_limit_reverse: assert property ($rose(positive_limit_sensor) && motor_dir
        && !current_limit_en |-> ##[1:8] !motor_dir)
        else $error("no reversal at limit");
endmodule
bind rth_sequencer rth_sequencer_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .ready, .origin_done, .motor_step,
    .motor_dir, .current_limit, .current_limit_en, .stall_detect, .positive_limit_sensor);
`default_nettype wire

// ===== testbench/rth_motor_model.sv
// motor, limit sensor, end stop and external signal model
`timescale 1ns/1ps
`default_nettype none
module rth_motor_model #(
    parameter int POS_HI = 20,
    parameter int POS_LO = -1000,
    parameter int PUSH_END = -1,
    parameter int APT_POS = -181
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset
    input wire logic motor_step, // step pulse
    input wire logic motor_dir, // 1 positive
    input wire logic current_limit_en, // push current on
    output logic positive_limit_sensor, // high at top end
    output logic negative_limit_sensor, // high at low end
    output logic stall_detect, // pressed on end
    output logic external_aperture_input, // aperture seen
    output logic excitation_phase_marker, // phase marker
    output logic signed [31:0] pos, // shaft position
    output logic signed [31:0] max_pos // furthest positive
);
    // shaft position follows every step pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos <= 0;
            max_pos <= 0;
        end else if (motor_step) begin
            pos <= motor_dir ? pos + 1 : pos - 1;
            if (motor_dir && pos + 1 > max_pos) begin
                max_pos <= pos + 1;
            end
        end
    end
    assign positive_limit_sensor = (pos >= POS_HI);
    assign negative_limit_sensor = (pos <= POS_LO);
    // end stop only felt as stall while pushing at limited current
    assign stall_detect = current_limit_en && (pos <= PUSH_END);
    assign external_aperture_input = (pos <= APT_POS);
    // toggles every step so a stale level never reads as a match
    assign excitation_phase_marker = pos[0];
endmodule
`default_nettype wire

// ===== testbench/tb_return_to_home_sequencer.sv
// self-checking bench for the return-to-home sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_return_to_home_sequencer
    import rth_pkg::*;
;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} rth_row_t;
    logic aclk = 0, aresetn = 0, origin_search_request = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ready, origin_done, motor_step, motor_dir, current_limit_en;
    logic positive_limit_sensor, negative_limit_sensor, external_aperture_input;
    logic excitation_phase_marker, stall_detect;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [10:0] current_limit;
    logic signed [31:0] pos, max_pos;
    int fail_count = 0, total_checks = 0;
    rth_row_t rows [13];

    initial forever #5 aclk = ~aclk;

    rth_sequencer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .origin_search_request, .ready,
        .origin_done, .positive_limit_sensor, .negative_limit_sensor, .external_aperture_input,
        .excitation_phase_marker, .stall_detect, .motor_step, .motor_dir, .current_limit,
        .current_limit_en);
    rth_motor_model u_motor (.aclk, .aresetn, .motor_step, .motor_dir, .current_limit_en,
        .positive_limit_sensor, .negative_limit_sensor, .stall_detect,
        .external_aperture_input, .excitation_phase_marker, .pos, .max_pos);

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one transfer; each channel released at the edge it is taken
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ap;
        logic dp;
        ap = 1'b1;
        dp = wr;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        for (n = 0; n < 1000; n++) begin
            @(posedge aclk);
            if (ap && (wr ? s_axi_awready : s_axi_arready)) begin
                ap = 1'b0;
                s_axi_awvalid <= 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (dp && s_axi_wready) begin
                dp = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (wr ? s_axi_bvalid : s_axi_rvalid) begin
                q = s_axi_rdata;
                r = wr ? s_axi_bresp : s_axi_rresp;
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        chk("axi answer", 32'h0, 32'h1);
        summarize();
    endtask

    // bounded wait: 0 ready, 1 origin_done, 2 motor_dir, 3 motor_step
    task automatic wait_for(input int sel, input logic v, input int lim);
        int n;
        logic s;
        for (n = 0; n < lim; n++) begin
            @(posedge aclk);
            s = sel == 0 ? ready : sel == 1 ? origin_done : sel == 2 ? motor_dir : motor_step;
            if (s === v) return;
        end
        chk("wait", 32'(sel), 32'hff);
        summarize();
    endtask

    initial begin
        rows = '{'{0, RTH_REG_START_SPEED, 32'h1f4, 2'b00}, '{0, RTH_REG_RUN_SPEED, 32'h3e8, 2'b00},
            '{0, RTH_REG_PUSH_CURRENT, 32'h3e8, 2'b00}, '{0, RTH_REG_OFFSET, 32'h0, 2'b00},
            '{0, RTH_REG_APPROACH, 32'h1f4, 2'b00}, '{0, RTH_REG_STATUS, 32'h1, 2'b00},
            '{1, RTH_REG_START_SPEED, 32'h1f3, 2'b00}, '{0, RTH_REG_APPROACH, 32'h1f3, 2'b00},
            '{1, RTH_REG_PUSH_CURRENT, 32'h7d0, 2'b00}, '{0, RTH_REG_PUSH_CURRENT, 32'h3e8, 2'b00},
            '{1, RTH_REG_STATUS, 32'h0, 2'b10}, '{1, RTH_REG_APPROACH, 32'h0, 2'b10},
            '{0, 8'h1c, 32'h0, 2'b10}};
        repeat (5) @(posedge aclk);
        chk("ready", ready, 32'h1);
        chk("origin_done", origin_done, 32'h0);
        chk("awready", s_axi_awready, 32'h1);
        aresetn <= 1'b1;
        $display("test reset done");
        foreach (rows[i]) begin
            axi(rows[i].wr, rows[i].a, rows[i].d);
            chk("resp", r, rows[i].r);
            if (!rows[i].wr) chk("rdata", q, rows[i].d);
        end
        $display("test registers done");
        // push seek kept at 1500 Hz, well under the shaft speed ceiling
        axi(1, RTH_REG_RUN_SPEED, 32'h5dc);
        axi(1, RTH_REG_START_SPEED, 32'h5dc);
        axi(1, RTH_REG_PUSH_CURRENT, 32'h258);
        axi(1, RTH_REG_CTRL, 32'h2);
        chk("ready", ready, 32'h1);
        origin_search_request <= 1'b1;
        wait_for(0, 1'b0, 100);
        origin_search_request <= 1'b0;
        wait_for(3, 1'b1, 100000);
        chk("current_limit_en", current_limit_en, 32'h1);
        chk("current_limit", current_limit, 32'h258);
        wait_for(2, 1'b1, 400000);
        chk("push pos", pos, 32'hffffffff);
        // reset in mid-search, after the stall reversal, must leave ready set and push current off
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        chk("ready", ready, 32'h1);
        chk("current_limit_en", current_limit_en, 32'h0);
        aresetn <= 1'b1;
        $display("test push done");
        axi(1, RTH_REG_RUN_SPEED, 32'hf4240);
        axi(1, RTH_REG_START_SPEED, 32'hf4240);
        axi(1, RTH_REG_OFFSET, 32'h3);
        axi(1, RTH_REG_CTRL, 32'h1d);
        wait_for(1, 1'b1, 40000);
        chk("max_pos", max_pos, 32'd20);
        chk("final pos", pos, 32'hffffff48);
        axi(0, RTH_REG_STATUS, 32'h0);
        chk("status", q, 32'h3);
        $display("test two-sensor done");
        summarize();
    end
endmodule
`default_nettype wire
